/* File: rtl/accel_interrupt_router.sv */
// Functional notes
// (RULE1) Wake bits let detection functions wake system
// (RULE2) Polarity bit sets interrupt active level
// (RULE3) Drive bit selects push-pull or open drain
// (RULE4) Per-source enable gates each event flag
// (RULE5) Enabled source reaches exactly one pin
// (RULE6) Routing bit 1 first pin, 0 second
// (RULE7) Pin asserts on OR of routed sources
// (RULE8) Host reads source status after interrupt
// (RULE9) Sleep/wake interrupt on every mode change
// (RULE10) Only four detectors affect wake/sleep
// (RULE11) Unused register bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none

module accel_interrupt_router
  import irq_router_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Register port from the sensor core
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  output var  logic       reg_rvalid,
  // Function event flags
  input  wire logic       transient_flag,
  input  wire logic       orientation_flag,
  input  wire logic       pulse_flag,
  input  wire logic       fall_motion_flag,
  input  wire logic       sample_ready_flag,
  // Sleep state from the core and its clear
  input  wire logic       in_sleep,
  input  wire logic       sleep_wake_clear,
  // Wake control to the core
  output var  logic       wake_request,
  output var  logic       keep_awake,
  // Interrupt pins
  input  wire logic       irq_pin_first_in,
  output logic            irq_pin_first_out,
  output logic            irq_pin_first_oe,
  input  wire logic       irq_pin_second_in,
  output logic            irq_pin_second_out,
  output logic            irq_pin_second_oe
);

  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] enable_reg;
  logic [7:0] enable_next;
  logic [7:0] routing_reg;
  logic [7:0] routing_next;
  logic       sleep_prev_reg;
  logic       sleep_prev_next;
  logic       sleep_flag_reg;
  logic       sleep_flag_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;
  logic       wake_reg;
  logic       wake_next;
  logic       awake_reg;
  logic       awake_next;
  logic [7:0] raw_src;
  logic [7:0] pending;
  logic [7:0] detect_mask;
  logic [7:0] wake_mask;
  logic [7:0] detect_src;
  logic [7:0] wake_src;
  logic [PIN_COUNT-1:0] pin_assert;

  // Source vector in status layout
  always_comb begin
    raw_src                   = 8'h00;
    raw_src[SRC_SLEEP_WAKE]   = sleep_flag_reg;
    raw_src[SRC_TRANSIENT]    = transient_flag;
    raw_src[SRC_ORIENTATION]  = orientation_flag;
    raw_src[SRC_PULSE]        = pulse_flag;
    raw_src[SRC_FALL_MOTION]  = fall_motion_flag;
    raw_src[SRC_SAMPLE_READY] = sample_ready_flag;
    pending     = raw_src & enable_reg;  // [RULE4]
    pin_assert[PIN_FIRST]  = |(pending & routing_reg);  // [RULE5] [RULE6] [RULE7]
    pin_assert[PIN_SECOND] = |(pending & ~routing_reg);  // [RULE5] [RULE6] [RULE7]
    // Detection functions only
    detect_mask                  = 8'h00;
    detect_mask[SRC_TRANSIENT]   = 1'b1;
    detect_mask[SRC_ORIENTATION] = 1'b1;
    detect_mask[SRC_PULSE]       = 1'b1;
    detect_mask[SRC_FALL_MOTION] = 1'b1;
    wake_mask                  = 8'h00;
    wake_mask[SRC_TRANSIENT]   = cfg_reg[WAKE_ON_TRANSIENT];
    wake_mask[SRC_ORIENTATION] = cfg_reg[WAKE_ON_ORIENTATION];
    wake_mask[SRC_PULSE]       = cfg_reg[WAKE_ON_PULSE];
    wake_mask[SRC_FALL_MOTION] = cfg_reg[WAKE_ON_FALL_MOTION];
    detect_src                 = raw_src & detect_mask;
    wake_src                   = detect_src & wake_mask;
  end

  // Register writes and reads
  always_comb begin
    cfg_next     = cfg_reg;
    enable_next  = enable_reg;
    routing_next = routing_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_WAKE_AND_PIN_CFG:  cfg_next     = reg_wdata & WAKE_AND_PIN_CFG_MASK;  // [RULE11]
        ADDR_IRQ_SOURCE_ENABLE: enable_next  = reg_wdata & SOURCE_MASK;  // [RULE11]
        ADDR_IRQ_PIN_ROUTING:   routing_next = reg_wdata & SOURCE_MASK;  // [RULE11]
        default: ;
      endcase
    end
    rvalid_next = reg_rd;
    rdata_next  = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_IRQ_SOURCE_STATUS: rdata_next = pending;  // [RULE8]
        ADDR_WAKE_AND_PIN_CFG:  rdata_next = cfg_reg;
        ADDR_IRQ_SOURCE_ENABLE: rdata_next = enable_reg;
        ADDR_IRQ_PIN_ROUTING:   rdata_next = routing_reg;
        default:                rdata_next = 8'h00;
      endcase
    end
  end

  // Sleep/wake change event, set wins over clear
  always_comb begin
    sleep_prev_next = in_sleep;
    sleep_flag_next = sleep_flag_reg;
    if (sleep_wake_clear) begin
      sleep_flag_next = 1'b0;
    end
    if (in_sleep != sleep_prev_reg) begin
      sleep_flag_next = 1'b1;  // [RULE9]
    end
  end

  // Wake and keep-awake from the four detectors
  always_comb begin
    wake_next  = in_sleep && |(raw_src & detect_mask & wake_mask);  // [RULE1] [RULE10]
    awake_next = !in_sleep && |(raw_src & detect_mask & enable_reg);  // [RULE10]
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_reg        <= WAKE_AND_PIN_CFG_RESET;
      enable_reg     <= IRQ_SOURCE_ENABLE_RESET;
      routing_reg    <= IRQ_PIN_ROUTING_RESET;
      sleep_prev_reg <= 1'b0;
      sleep_flag_reg <= 1'b0;
      rdata_reg      <= 8'h00;
      rvalid_reg     <= 1'b0;
      wake_reg       <= 1'b0;
      awake_reg      <= 1'b0;
    end else begin
      cfg_reg        <= cfg_next;
      enable_reg     <= enable_next;
      routing_reg    <= routing_next;
      sleep_prev_reg <= sleep_prev_next;
      sleep_flag_reg <= sleep_flag_next;
      rdata_reg      <= rdata_next;
      rvalid_reg     <= rvalid_next;
      wake_reg       <= wake_next;
      awake_reg      <= awake_next;
    end
  end

  assign reg_rdata    = rdata_reg;
  assign reg_rvalid   = rvalid_reg;
  assign wake_request = wake_reg;
  assign keep_awake   = awake_reg;

  // Pin drivers
  logic [PIN_COUNT-1:0] pad_out;
  logic [PIN_COUNT-1:0] pad_oe;

  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    irq_pad_if pad_bus ();
    assign pad_bus.asserted    = pin_assert[g];
    assign pad_bus.active_high = cfg_reg[IRQ_ACTIVE_LEVEL];  // [RULE2]
    assign pad_bus.open_drain  = cfg_reg[IRQ_DRIVE_TYPE];  // [RULE3]
    irq_pad_driver u_pad (
      .sys_clk (sys_clk),
      .reset   (reset),
      .pad     (pad_bus.pad)
    );
    assign pad_out[g] = pad_bus.pad_out;
    assign pad_oe[g]  = pad_bus.pad_oe;
  end

  assign irq_pin_first_out  = pad_out[PIN_FIRST];
  assign irq_pin_first_oe   = pad_oe[PIN_FIRST];
  assign irq_pin_second_out = pad_out[PIN_SECOND];
  assign irq_pin_second_oe  = pad_oe[PIN_SECOND];

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_wake_gated: assert property (
    wake_request |-> $past(in_sleep) && ($past(wake_src) != 8'h00))  // [RULE1]
    else $error("wake request without enabled detector");

  a_pin_level: assert property (
    pin_assert[PIN_FIRST] && cfg_reg[IRQ_ACTIVE_LEVEL] && !cfg_reg[IRQ_DRIVE_TYPE]
    ##1 $stable(cfg_reg) |-> irq_pin_first_out && irq_pin_first_oe)  // [RULE2]
    else $error("first pin not at active-high level");

  a_open_drain: assert property (
    !$past(reset) && $past(cfg_reg[IRQ_DRIVE_TYPE])
    |-> !irq_pin_first_out && !irq_pin_second_out)  // [RULE3]
    else $error("open-drain pin driven high");

  a_disabled_src: assert property (
    (raw_src & ~enable_reg) != 8'h00 && (raw_src & enable_reg) == 8'h00
    |-> pin_assert == '0)  // [RULE4]
    else $error("disabled source reached a pin");

  a_exactly_one: assert property (
    $onehot(pending) |-> $onehot(pin_assert))  // [RULE5]
    else $error("single source not on exactly one pin");

  a_route_second: assert property (
    pending[SRC_SAMPLE_READY] && !routing_reg[SRC_SAMPLE_READY]
    |-> pin_assert[PIN_SECOND])  // [RULE6]
    else $error("routing bit 0 did not select second pin");

  a_or_of_sources: assert property (
    !pin_assert[PIN_FIRST] |-> (pending & routing_reg) == 8'h00)  // [RULE7]
    else $error("first pin idle with routed source pending");

  a_sleep_event: assert property (
    $changed(in_sleep) && !$past(reset) |=> sleep_flag_reg)  // [RULE9]
    else $error("sleep transition not flagged");

  a_no_keepawake: assert property (
    keep_awake |-> !$past(in_sleep) && ($past(detect_src) != 8'h00))  // [RULE10]
    else $error("keep awake from non-detector source");

  a_reserved_zero: assert property (
    (cfg_reg & ~WAKE_AND_PIN_CFG_MASK) == 8'h00 && (enable_reg & ~SOURCE_MASK) == 8'h00
    && (routing_reg & ~SOURCE_MASK) == 8'h00)  // [RULE11]
    else $error("reserved register bit set");

  c_first_pin: cover property (pin_assert[PIN_FIRST] ##1 !pin_assert[PIN_FIRST]);
  c_both_pins: cover property (pin_assert == 2'b11);
  c_wake: cover property (in_sleep ##1 wake_request);
  c_open_drain_high: cover property (cfg_reg[IRQ_DRIVE_TYPE] && cfg_reg[IRQ_ACTIVE_LEVEL]
    && pin_assert[PIN_SECOND]);

endmodule : accel_interrupt_router

`default_nettype wire

/* File: rtl/irq_router_pkg.sv */
package irq_router_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_IRQ_SOURCE_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_WAKE_AND_PIN_CFG  = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_SOURCE_ENABLE = 8'h2D;
  localparam logic [7:0] ADDR_IRQ_PIN_ROUTING   = 8'h2E;

  // Reset values
  localparam logic [7:0] WAKE_AND_PIN_CFG_RESET  = 8'h00;
  localparam logic [7:0] IRQ_SOURCE_ENABLE_RESET = 8'h00;
  localparam logic [7:0] IRQ_PIN_ROUTING_RESET   = 8'h00;

  // Writable bit masks, unused positions stay zero
  localparam logic [7:0] WAKE_AND_PIN_CFG_MASK = 8'h7B;
  localparam logic [7:0] SOURCE_MASK           = 8'hBD;

  // Source bit positions, shared by enable, routing and status
  localparam int SRC_SLEEP_WAKE   = 7;
  localparam int SRC_TRANSIENT    = 5;
  localparam int SRC_ORIENTATION  = 4;
  localparam int SRC_PULSE        = 3;
  localparam int SRC_FALL_MOTION  = 2;
  localparam int SRC_SAMPLE_READY = 0;

  // Wake and pin configuration bit positions
  localparam int WAKE_ON_TRANSIENT   = 6;
  localparam int WAKE_ON_ORIENTATION = 5;
  localparam int WAKE_ON_PULSE       = 4;
  localparam int WAKE_ON_FALL_MOTION = 3;
  localparam int IRQ_ACTIVE_LEVEL    = 1;
  localparam int IRQ_DRIVE_TYPE      = 0;

  // Pin indices
  localparam int PIN_FIRST  = 0;
  localparam int PIN_SECOND = 1;
  localparam int PIN_COUNT  = 2;

endpackage : irq_router_pkg

/* File: rtl/irq_pad_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface irq_pad_if;
  logic asserted;
  logic active_high;
  logic open_drain;
  logic pad_out;
  logic pad_oe;

  modport ctrl (output asserted, output active_high, output open_drain,
                input pad_out, input pad_oe);
  modport pad  (input asserted, input active_high, input open_drain,
                output pad_out, output pad_oe);
endinterface : irq_pad_if

`default_nettype wire

/* File: rtl/irq_pad_driver.sv */
`timescale 1ns/1ps
`default_nettype none

module irq_pad_driver (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Pad control
  irq_pad_if.pad    pad
);

  logic out_reg;
  logic out_next;
  logic oe_reg;
  logic oe_next;
  logic level;

  // Level on the wire and drive mode
  always_comb begin
    level = pad.asserted ? pad.active_high : ~pad.active_high;  // [RULE2]
    if (pad.open_drain) begin  // [RULE3]
      out_next = 1'b0;
      oe_next  = ~level;
    end else begin
      out_next = level;
      oe_next  = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_reg <= 1'b1;
      oe_reg  <= 1'b1;
    end else begin
      out_reg <= out_next;
      oe_reg  <= oe_next;
    end
  end

  assign pad.pad_out = out_reg;
  assign pad.pad_oe  = oe_reg;

  a_push_pull_level: assert property (@(posedge sys_clk) disable iff (reset)
    !pad.open_drain |=> oe_reg && (out_reg == $past(level)))  // [RULE2]
    else $error("push-pull pad level wrong");

  a_open_drain_rel: assert property (@(posedge sys_clk) disable iff (reset)
    pad.open_drain |=> !out_reg && (oe_reg == !$past(level)))  // [RULE3]
    else $error("open-drain pad drive wrong");

endmodule : irq_pad_driver

`default_nettype wire

/* File: testbench/irq_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module irq_host_model (
  // Pad drive from the device
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  // Resolved line levels
  output logic      [1:0] pin_wire
);
  // Pull-up on each line, released pad reads high
  assign pin_wire[0] = pin_oe[0] ? pin_out[0] : 1'h1;
  assign pin_wire[1] = pin_oe[1] ? pin_out[1] : 1'h1;
endmodule : irq_host_model

`default_nettype wire

/* File: testbench/accel_interrupt_router_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module accel_interrupt_router_tb;
  import irq_router_pkg::*;
  logic       sys_clk = 1'h0;
  logic       reset, reg_wr, reg_rd, rvalid, in_sleep, sleep_wake_clear;
  logic       wake_request, keep_awake, sw, slp;
  logic [7:0] reg_addr, reg_wdata, rdata, flags, cfg, en, rt, nxt, pend, act;
  logic [1:0] p_out, p_oe, p_wire, lvl;
  integer     seed, error_cnt, num_checks, i;

  always #2.5 sys_clk = ~sys_clk;

  accel_interrupt_router dut (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .transient_flag(flags[SRC_TRANSIENT]), .orientation_flag(flags[SRC_ORIENTATION]),
    .pulse_flag(flags[SRC_PULSE]), .fall_motion_flag(flags[SRC_FALL_MOTION]),
    .sample_ready_flag(flags[SRC_SAMPLE_READY]), .in_sleep(in_sleep),
    .sleep_wake_clear(sleep_wake_clear), .wake_request(wake_request),
    .keep_awake(keep_awake), .irq_pin_first_in(p_wire[0]), .irq_pin_first_out(p_out[0]),
    .irq_pin_first_oe(p_oe[0]), .irq_pin_second_in(p_wire[1]),
    .irq_pin_second_out(p_out[1]), .irq_pin_second_oe(p_oe[1]));

  irq_host_model host (.pin_out(p_out), .pin_oe(p_oe), .pin_wire(p_wire));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'h0;
    #1;
    check("rvalid", {7'h0, rvalid}, 8'h01);
    check("rdata", rdata, exp);
  endtask : rd

  // Wire level per pin: asserted shows the polarity bit
  function automatic logic [1:0] exp_lvl(input logic [7:0] a, input logic [7:0] r,
                                         input logic [7:0] c);
    return ~({|(a & ~r), |(a & r)} ^ {2{c[IRQ_ACTIVE_LEVEL]}});
  endfunction : exp_lvl

  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    seed = 5;
    error_cnt = 0;
    num_checks = 0;
    reset = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    flags = 8'h00;
    in_sleep = 1'h0;
    sleep_wake_clear = 1'h0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'h0;
    rd(ADDR_WAKE_AND_PIN_CFG, WAKE_AND_PIN_CFG_RESET);
    rd(ADDR_IRQ_SOURCE_ENABLE, IRQ_SOURCE_ENABLE_RESET);
    rd(ADDR_IRQ_PIN_ROUTING, IRQ_PIN_ROUTING_RESET);
    check("idle oe", {6'h0, p_oe}, 8'h03);
    check("idle wire", {6'h0, p_wire}, 8'h03);
    wr(8'h2F, 8'hFF);
    rd(8'h2F, 8'h00);
    for (i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      sleep_wake_clear <= 1'h1;
      @(posedge sys_clk);
      sleep_wake_clear <= 1'h0;
      cfg = 8'($random(seed));
      en  = 8'($random(seed));
      rt  = 8'($random(seed));
      if (i == 0) {cfg, en, rt} = 24'hFFFFFF;
      if (i == 1) {cfg, en, rt} = 24'h03FF00;
      wr(ADDR_WAKE_AND_PIN_CFG, cfg);
      wr(ADDR_IRQ_SOURCE_ENABLE, en);
      wr(ADDR_IRQ_PIN_ROUTING, rt);
      cfg &= WAKE_AND_PIN_CFG_MASK;
      en  &= SOURCE_MASK;
      rt  &= SOURCE_MASK;
      if (i == 0) rd(ADDR_WAKE_AND_PIN_CFG, 8'h7B);
      if (i == 0) rd(ADDR_IRQ_PIN_ROUTING, 8'hBD);
      nxt  = 8'($random(seed)) & 8'h3D;
      slp  = 1'($random(seed));
      sw   = (slp !== in_sleep);
      pend = nxt | {sw, 7'h00};
      @(posedge sys_clk);
      flags    <= nxt;
      in_sleep <= slp;
      repeat (3) @(posedge sys_clk);
      #1;
      act = pend & en;
      lvl = exp_lvl(act, rt, cfg);
      check("pin wire", {6'h0, p_wire}, {6'h0, lvl});
      check("pin oe", {6'h0, p_oe}, {6'h0, cfg[IRQ_DRIVE_TYPE] ? ~lvl : 2'h3});
      check("pin out", {6'h0, p_out}, {6'h0, cfg[IRQ_DRIVE_TYPE] ? 2'h0 : lvl});
      check("keep_awake", {7'h0, keep_awake}, {7'h0, ~slp & |(nxt & en & 8'h3C)});
      check("wake_request", {7'h0, wake_request}, {7'h0, slp & |(nxt & (cfg >> 1) & 8'h3C)});
      rd(ADDR_IRQ_SOURCE_STATUS, act);
    end
    // Mode change in the same cycle as the clear: set wins
    wr(ADDR_IRQ_SOURCE_ENABLE, 8'h80);
    @(posedge sys_clk);
    sleep_wake_clear <= 1'h1;
    @(posedge sys_clk);
    in_sleep         <= ~in_sleep;
    @(posedge sys_clk);
    sleep_wake_clear <= 1'h0;
    rd(ADDR_IRQ_SOURCE_STATUS, 8'h80);
    @(posedge sys_clk);
    sleep_wake_clear <= 1'h1;
    @(posedge sys_clk);
    sleep_wake_clear <= 1'h0;
    rd(ADDR_IRQ_SOURCE_STATUS, 8'h00);
    end_of_test();
  end
endmodule : accel_interrupt_router_tb

`default_nettype wire
